/* File: etis_pkg.sv */
package etis_pkg;

    // Register port widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00; // Global and direct enables
    localparam logic [7:0] OFF_ENB = 8'h04; // Multi-function member enables
    localparam logic [7:0] OFF_FLAG = 8'h08; // Request flags
    localparam logic [7:0] OFF_EDGE = 8'h0C; // Edge select per line
    localparam logic [7:0] OFF_PULL = 8'h10; // Pull-high selects
    localparam logic [7:0] OFF_VEC = 8'h14; // Pending vector, read only
    localparam logic [7:0] OFF_LVL = 8'h18; // Filtered pin levels, read only

    // Control register fields
    localparam int unsigned CTRL_GIE = 0;
    localparam int unsigned CTRL_EN0 = 1;
    localparam int unsigned CTRL_EN1 = 2;
    localparam int unsigned CTRL_TA = 3;
    localparam int unsigned CTRL_TB = 4;
    localparam int unsigned CTRL_MF = 5;

    // Member enable register fields
    localparam int unsigned ENB_PER = 0;
    localparam int unsigned ENB_TC = 1;
    localparam int unsigned ENB_TD = 2;

    // Flag register fields
    localparam int unsigned FLAG_L0 = 0;
    localparam int unsigned FLAG_L1 = 1;
    localparam int unsigned FLAG_TA = 2;
    localparam int unsigned FLAG_TB = 3;
    localparam int unsigned FLAG_MF = 4;
    localparam int unsigned FLAG_PER = 5;
    localparam int unsigned FLAG_TC = 6;
    localparam int unsigned FLAG_TD = 7;

    // Edge select fields, two bits per line
    localparam int unsigned EDGE_L0_LSB = 0;
    localparam int unsigned EDGE_L1_LSB = 2;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [2:0] ENB_RST = 3'h0;
    localparam logic [7:0] FLAG_RST = 8'h00;
    localparam logic [3:0] EDGE_RST = 4'h0;
    localparam logic [1:0] PULL_RST = 2'h0;

    // Edge select encoding
    typedef enum logic [1:0] {
        EDGE_OFF = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } etis_edge_t;

    // Call vectors
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam logic [7:0] VEC_L0 = 8'h04;
    localparam logic [7:0] VEC_L1 = 8'h08;
    localparam logic [7:0] VEC_TA = 8'h0C;
    localparam logic [7:0] VEC_TB = 8'h10;
    localparam logic [7:0] VEC_MF = 8'h18;

    // Noise filter timing: least stable time, rounded up to cycles
    localparam int unsigned CLK_NS = 8;
    localparam int unsigned FILT_NS = 24;
    localparam int unsigned FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned FILT_CNT_W = 2;
    localparam logic [1:0] FILT_LAST = 2'(FILT_CYC - 1);

    // Conditioned pin count: line a, line b, peripheral, two timer inputs
    localparam int unsigned NPIN = 5;

endpackage

/* File: etis_cond_if.sv */
`timescale 1ns/10ps
interface etis_cond_if;
    logic level; // Filtered, synchronised level
    logic rise; // One-cycle pulse on rising edge
    logic fall; // One-cycle pulse on falling edge
    modport drv (output level, output rise, output fall);
    modport use_side (input level, input rise, input fall);
endinterface

/* File: etis_pin_cond.sv */
`timescale 1ns/10ps
module etis_pin_cond #(
    parameter bit FILTER_ON = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    etis_cond_if.drv cond
);
    logic [1:0] sync_q, sync_d; // Two-stage synchroniser
    logic level_q, level_d; // Accepted level
    logic [etis_pkg::FILT_CNT_W-1:0] cnt_q, cnt_d; // Stability count
    logic [2:0] prime_q, prime_d; // Primed once the synchroniser holds pin
    logic rise_q, rise_d;
    logic fall_q, fall_d;

    // Filter: a new level must hold for the whole filter time
    always_comb begin
        sync_d = {sync_q[0], pin_i};
        level_d = level_q;
        cnt_d = '0;
        prime_d = {prime_q[1:0], 1'b1};
        if (!prime_q[2] || !FILTER_ON) begin
            // Bypass, or synchroniser still filling: take level at once
            level_d = sync_q[1];
        end else if (sync_q[1] != level_q) begin
            if (cnt_q == etis_pkg::FILT_LAST) begin
                level_d = sync_q[1];
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
        // No edge on the priming sample, avoids a false edge at reset
        rise_d = prime_q[2] && level_d && !level_q;
        fall_d = prime_q[2] && !level_d && level_q;
    end

    // Registers only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_q <= 2'h0;
            level_q <= 1'b0;
            cnt_q <= '0;
            prime_q <= 3'h0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            level_q <= level_d;
            cnt_q <= cnt_d;
            prime_q <= prime_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    assign cond.level = level_q;
    assign cond.rise = rise_q;
    assign cond.fall = fall_q;

    // Filtered level only moves after three equal samples
    AST_FILT_STABLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (FILTER_ON && $past(prime_q[2]) && $changed(level_q)) |->
        ($past(sync_q[1], 1) == level_q && $past(sync_q[1], 2) == level_q &&
         $past(sync_q[1], 3) == level_q))
        else $error("Filter passed a short spike");

endmodule // etis_pin_cond

/* File: etis_irq_ctrl.sv */
`timescale 1ns/10ps
// What this block does
// - Line irq needs global, line enable, edge on
// - Selected edge on pin sets line flag
// - Lines call 04H or 08H, stack not full
// - Line service clears its flag and global
// - Pull-high select stays active during irq use
// - Edge select: rising, falling, both, or off
// - Noise filter on inputs, build-time bypass
// - One bypass for all filtered inputs
// - Peripheral irq needs global, own, multi enables
// - Falling peripheral pin sets peripheral flag
// - Peripheral pin or LCD segment, build option
// - Peripheral calls 18H, software clears own flag
// - Timers a, b flag on overflow, enabled service
// - Timer a calls 0CH, timer b 10H
// - Timer a, b service clears flag, global
// - Timers c, d flag, gated via multi path
// - Timers c, d call 18H, software clears
// - Fixed priority 04H up to 18H
// - Member request sets multi flag
// - Flags stay set until service or clear
module etis_irq_ctrl #(
    parameter bit FILTER_ON = 1'b1, // Common noise filter option
    parameter bit PERIPH_IS_IRQ = 1'b1 // Pin is irq input, else segment
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    input wire logic ext_irq_pin_a_i,
    input wire logic ext_irq_pin_b_i,
    input wire logic periph_irq_pin_i,
    input wire logic [1:0] timer_ext_pin_i,
    output logic [1:0] timer_ext_filt_o,
    input wire logic [3:0] timer_ovf_i,
    input wire logic [1:0] port_d_direction_i,
    input wire logic stack_full_i,
    input wire logic irq_ack_i,
    output logic irq_req_o,
    output logic [7:0] irq_vector_o,
    output logic [1:0] pullup_en_o,
    input wire logic lcd_seg_data_i,
    output logic lcd_seg_o,
    output logic lcd_seg_oe_o
);
    // Software-visible state
    logic [7:0] ctrl_q, ctrl_d; // Global and direct enables
    logic [2:0] enb_q, enb_d; // Multi-function member enables
    logic [7:0] flag_q, flag_d; // Request flags
    logic [3:0] edge_q, edge_d; // Edge select, two lines
    logic [1:0] pull_q, pull_d; // Pull-high selects
    // Call request toward the core
    logic irq_req_q, irq_req_d;
    logic [7:0] irq_vector_q, irq_vector_d;
    // Read data and pin-side outputs
    logic [7:0] rdata_q, rdata_d;
    logic lcd_seg_q, lcd_seg_d;
    logic lcd_oe_q, lcd_oe_d;

    // Conditioned pin views
    logic [etis_pkg::NPIN-1:0] pin_raw;
    logic [etis_pkg::NPIN-1:0] lvl;
    logic [etis_pkg::NPIN-1:0] rise;
    logic [etis_pkg::NPIN-1:0] fall;

    // Decoded events and eligibility
    logic line0_hit, line1_hit, per_hit, mf_hit;
    logic [7:0] set_vec;
    logic elig_l0, elig_l1, elig_ta, elig_tb, elig_mf;
    logic ack_ok;

    // All five inputs share one filter option, no per-pin choice
    assign pin_raw = {timer_ext_pin_i, periph_irq_pin_i,
                      ext_irq_pin_b_i, ext_irq_pin_a_i};

    generate
        for (genvar g = 0; g < etis_pkg::NPIN; g++) begin : g_pin
            etis_cond_if c_if ();
            etis_pin_cond #(
                .FILTER_ON(FILTER_ON)
            ) u_cond (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .pin_i(pin_raw[g]),
                .cond(c_if.drv)
            );
            assign lvl[g] = c_if.level;
            assign rise[g] = c_if.rise;
            assign fall[g] = c_if.fall;
        end
    endgenerate

    // Edge qualifier per line; off blocks the line entirely
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic r, input logic f);
        etis_pkg::etis_edge_t e;
        e = etis_pkg::etis_edge_t'(sel);
        unique case (e)
            etis_pkg::EDGE_RISE: edge_hit = r;
            etis_pkg::EDGE_FALL: edge_hit = f;
            etis_pkg::EDGE_BOTH: edge_hit = r | f;
            etis_pkg::EDGE_OFF: edge_hit = 1'b0;
        endcase
    endfunction

    // Hardware set events for each flag
    always_comb begin
        // Pin only counts while the port bit makes it an input
        line0_hit = port_d_direction_i[0] && ctrl_q[etis_pkg::CTRL_EN0] &&
            edge_hit(edge_q[etis_pkg::EDGE_L0_LSB +: 2], rise[0],
                     fall[0]);
        line1_hit = port_d_direction_i[1] && ctrl_q[etis_pkg::CTRL_EN1] &&
            edge_hit(edge_q[etis_pkg::EDGE_L1_LSB +: 2], rise[1],
                     fall[1]);
        // Segment mode leaves the peripheral flag untouched
        per_hit = PERIPH_IS_IRQ && fall[2];
        // A member raises the multi flag only while its enable is set
        mf_hit = (per_hit && enb_q[etis_pkg::ENB_PER]) ||
            (timer_ovf_i[2] && enb_q[etis_pkg::ENB_TC]) ||
            (timer_ovf_i[3] && enb_q[etis_pkg::ENB_TD]);
        set_vec = 8'h00;
        set_vec[etis_pkg::FLAG_L0] = line0_hit;
        set_vec[etis_pkg::FLAG_L1] = line1_hit;
        set_vec[etis_pkg::FLAG_TA] = timer_ovf_i[0];
        set_vec[etis_pkg::FLAG_TB] = timer_ovf_i[1];
        set_vec[etis_pkg::FLAG_MF] = mf_hit;
        set_vec[etis_pkg::FLAG_PER] = per_hit;
        set_vec[etis_pkg::FLAG_TC] = timer_ovf_i[2];
        set_vec[etis_pkg::FLAG_TD] = timer_ovf_i[3];
    end

    // Acknowledge only counts against a standing request
    assign ack_ok = irq_ack_i && irq_req_q;

    // Register file and flag next state
    always_comb begin
        ctrl_d = ctrl_q;
        enb_d = enb_q;
        flag_d = flag_q;
        edge_d = edge_q;
        pull_d = pull_q;
        if (reg_we_i) begin
            unique case (reg_addr_i)
                etis_pkg::OFF_CTRL: ctrl_d = reg_wdata_i;
                etis_pkg::OFF_ENB: enb_d = reg_wdata_i[2:0];
                etis_pkg::OFF_FLAG: flag_d = reg_wdata_i;
                etis_pkg::OFF_EDGE: edge_d = reg_wdata_i[3:0];
                etis_pkg::OFF_PULL: pull_d = reg_wdata_i[1:0];
                default: ; // Read-only or unmapped, write dropped
            endcase
        end
        // Service: global enable off, own flag cleared where owned
        if (ack_ok) begin
            ctrl_d[etis_pkg::CTRL_GIE] = 1'b0;
            unique case (irq_vector_q)
                etis_pkg::VEC_L0: flag_d[etis_pkg::FLAG_L0] = 1'b0;
                etis_pkg::VEC_L1: flag_d[etis_pkg::FLAG_L1] = 1'b0;
                etis_pkg::VEC_TA: flag_d[etis_pkg::FLAG_TA] = 1'b0;
                etis_pkg::VEC_TB: flag_d[etis_pkg::FLAG_TB] = 1'b0;
                // Member flags stay for software to clear
                etis_pkg::VEC_MF:
                    flag_d[etis_pkg::FLAG_MF] = 1'b0;
                default: ;
            endcase
        end
        // A new event beats any clear in the same cycle
        flag_d = flag_d | set_vec;
    end

    // Eligibility and fixed priority
    always_comb begin
        elig_l0 = flag_q[etis_pkg::FLAG_L0] && ctrl_q[etis_pkg::CTRL_EN0] &&
            (edge_q[etis_pkg::EDGE_L0_LSB +: 2] != etis_pkg::EDGE_OFF);
        elig_l1 = flag_q[etis_pkg::FLAG_L1] && ctrl_q[etis_pkg::CTRL_EN1] &&
            (edge_q[etis_pkg::EDGE_L1_LSB +: 2] != etis_pkg::EDGE_OFF);
        elig_ta = flag_q[etis_pkg::FLAG_TA] && ctrl_q[etis_pkg::CTRL_TA];
        elig_tb = flag_q[etis_pkg::FLAG_TB] && ctrl_q[etis_pkg::CTRL_TB];
        elig_mf = flag_q[etis_pkg::FLAG_MF] &&
            ctrl_q[etis_pkg::CTRL_MF];
        irq_vector_d = irq_vector_q;
        // No call while the stack is full; the flag simply waits
        irq_req_d = ctrl_q[etis_pkg::CTRL_GIE] && !stack_full_i && !ack_ok &&
            (elig_l0 || elig_l1 || elig_ta || elig_tb || elig_mf);
        if (elig_l0) begin
            irq_vector_d = etis_pkg::VEC_L0;
        end else if (elig_l1) begin
            irq_vector_d = etis_pkg::VEC_L1;
        end else if (elig_ta) begin
            irq_vector_d = etis_pkg::VEC_TA;
        end else if (elig_tb) begin
            irq_vector_d = etis_pkg::VEC_TB;
        end else if (elig_mf) begin
            irq_vector_d = etis_pkg::VEC_MF;
        end
        if (!irq_req_d) begin
            irq_vector_d = etis_pkg::VEC_NONE;
        end
    end

    // Read mux, data valid in the cycle after the strobe only
    always_comb begin
        rdata_d = 8'h00;
        if (reg_re_i) begin
            unique case (reg_addr_i)
                etis_pkg::OFF_CTRL: rdata_d = ctrl_q;
                etis_pkg::OFF_ENB: rdata_d = {5'h00, enb_q};
                etis_pkg::OFF_FLAG: rdata_d = flag_q;
                etis_pkg::OFF_EDGE: rdata_d = {4'h0, edge_q};
                etis_pkg::OFF_PULL: rdata_d = {6'h00, pull_q};
                etis_pkg::OFF_VEC: rdata_d = irq_vector_q;
                etis_pkg::OFF_LVL: rdata_d = {3'h0, lvl};
                default: rdata_d = 8'h00; // Unmapped reads zero
            endcase
        end
        // Segment function owns the pin when not an irq input
        lcd_seg_d = PERIPH_IS_IRQ ? 1'b0 : lcd_seg_data_i;
        lcd_oe_d = !PERIPH_IS_IRQ;
    end

    // State registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= etis_pkg::CTRL_RST;
            enb_q <= etis_pkg::ENB_RST;
            flag_q <= etis_pkg::FLAG_RST;
            edge_q <= etis_pkg::EDGE_RST;
            pull_q <= etis_pkg::PULL_RST;
            irq_req_q <= 1'b0;
            irq_vector_q <= etis_pkg::VEC_NONE;
            rdata_q <= 8'h00;
            lcd_seg_q <= 1'b0;
            lcd_oe_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            enb_q <= enb_d;
            flag_q <= flag_d;
            edge_q <= edge_d;
            pull_q <= pull_d;
            irq_req_q <= irq_req_d;
            irq_vector_q <= irq_vector_d;
            rdata_q <= rdata_d;
            lcd_seg_q <= lcd_seg_d;
            lcd_oe_q <= lcd_oe_d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata_o = rdata_q;
    assign irq_req_o = irq_req_q;
    assign irq_vector_o = irq_vector_q;
    // Pull-high not gated by irq use of the pin
    assign pullup_en_o = pull_q;
    assign timer_ext_filt_o = lvl[4:3];
    assign lcd_seg_o = lcd_seg_q;
    assign lcd_seg_oe_o = lcd_oe_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_GATE_GLOBAL: assert property (
        irq_req_o |-> $past(ctrl_q[etis_pkg::CTRL_GIE] && !stack_full_i))
        else $error("Request without global enable or with full stack");
    AST_ACK_CLEARS_GIE: assert property (
        ack_ok |=> !ctrl_q[etis_pkg::CTRL_GIE] && !irq_req_o)
        else $error("Service left global enable set");
    AST_LINE0_CLEARED: assert property (
        (ack_ok && irq_vector_o == etis_pkg::VEC_L0 && !line0_hit &&
         !reg_we_i)
        |=> !flag_q[etis_pkg::FLAG_L0])
        else $error("Line a flag not cleared on service");
    AST_PER_KEPT: assert property (
        (ack_ok && irq_vector_o == etis_pkg::VEC_MF && !reg_we_i &&
         flag_q[etis_pkg::FLAG_PER]) |=> flag_q[etis_pkg::FLAG_PER] &&
        !flag_q[etis_pkg::FLAG_MF] || $past(mf_hit))
        else $error("Peripheral flag lost on multi service");
    AST_EDGE_OFF: assert property (
        (edge_q[etis_pkg::EDGE_L0_LSB +: 2] == etis_pkg::EDGE_OFF &&
         !reg_we_i) |=>
        !$rose(flag_q[etis_pkg::FLAG_L0]))
        else $error("Disabled line a set its flag");
    AST_TA_SET: assert property (
        timer_ovf_i[0] |=> flag_q[etis_pkg::FLAG_TA])
        else $error("Timer a overflow lost");
    AST_MF_SET: assert property (
        mf_hit |=> flag_q[etis_pkg::FLAG_MF])
        else $error("Member request did not set multi flag");
    AST_PRIO_L0: assert property (
        (irq_req_d && elig_l0) |=> irq_vector_o == etis_pkg::VEC_L0)
        else $error("Line a lost priority");
    AST_TB_VEC: assert property (
        (irq_req_d && elig_tb && !elig_l0 && !elig_l1 && !elig_ta)
        |=> irq_vector_o == etis_pkg::VEC_TB)
        else $error("Timer b vector wrong");
    AST_FLAG_HOLD: assert property (
        (flag_q[etis_pkg::FLAG_TC] && !reg_we_i) |=> flag_q[etis_pkg::FLAG_TC])
        else $error("Timer c flag dropped without clear");

    COV_LINE0_CALL: cover property (
        ack_ok && irq_vector_o == etis_pkg::VEC_L0);
    COV_MF_CALL: cover property (
        ack_ok && irq_vector_o == etis_pkg::VEC_MF);
    COV_STACK_HOLD: cover property (
        stack_full_i && elig_ta && ctrl_q[etis_pkg::CTRL_GIE] ##1 !irq_req_o);
    COV_SET_VS_CLEAR: cover property (ack_ok && line0_hit);

endmodule // etis_irq_ctrl

/* File: etis_far_side.sv */
`timescale 1ns/10ps
// Far side: irq pins and timer overflow strobes
module etis_far_side (
    input wire logic clk_i,
    output logic [2:0] pin_o, // {periph, line b, line a}
    output logic [3:0] ovf_o // Timers a..d
);
    // Pins idle high so the first periph edge is a real fall
    initial begin
        pin_o = 3'h7;
        ovf_o = 4'h0;
    end
    // One-cycle overflow strobe on the system clock
    task automatic ovf(input logic [3:0] m);
        @(posedge clk_i) ovf_o <= m;
        @(posedge clk_i) ovf_o <= 4'h0;
    endtask
    // Level held n cycles; n of 0 makes a spike
    task automatic pin(input int i, input logic v, input int n);
        @(posedge clk_i) pin_o[i] <= v;
        repeat (n) @(posedge clk_i);
    endtask
endmodule // etis_far_side

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic clk_i, rst_n_i, we, re, stk, ack, seg, irq, oe, lseg;
    logic [7:0] addr, wd, rdata, vec, t;
    logic [1:0] dir, pu, tf, tpin;
    logic [2:0] pin;
    logic [3:0] ovf;
    int err_count, comparisons, m_ctrl, m_flag, m_enb, m_idx, m_edge; // Model
    etis_far_side far (.clk_i(clk_i), .pin_o(pin), .ovf_o(ovf));
    etis_irq_ctrl uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we),
        .reg_re_i(re), .reg_rdata_o(rdata), .ext_irq_pin_a_i(pin[0]),
        .ext_irq_pin_b_i(pin[1]), .periph_irq_pin_i(pin[2]),
        .timer_ext_pin_i(tpin), .timer_ext_filt_o(tf),
        .timer_ovf_i(ovf), .port_d_direction_i(dir),
        .stack_full_i(stk), .irq_ack_i(ack), .irq_req_o(irq),
        .irq_vector_o(vec), .pullup_en_o(pu), .lcd_seg_data_i(seg),
        .lcd_seg_o(lseg), .lcd_seg_oe_o(oe));
    // 125 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string n, input logic [7:0] s, e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_i) begin
            addr <= a;
            wd <= d;
            we <= 1'b1;
        end
        @(posedge clk_i) we <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdc(input string n, input logic [7:0] a, e);
        @(posedge clk_i) begin
            addr <= a;
            re <= 1'b1;
        end
        @(posedge clk_i) re <= 1'b0;
        #1 check(n, rdata, e);
    endtask
    // Highest eligible source in fixed order, or none
    function automatic logic [7:0] mvec();
        logic [7:0] vt [5];
        vt = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
        if (m_ctrl[0])
            for (int i = 0; i < 5; i++)
                if (m_flag[i] && m_ctrl[i + 1] &&
                    (i > 1 || m_edge[2 * i +: 2] != 0)) begin
                    m_idx = i;
                    return vt[i];
                end
        return 8'h00;
    endfunction
    // Overflow event and its model effect; multi flag only if member on
    task automatic tovf(input logic [3:0] m);
        far.ovf(m);
        if (m[0]) m_flag[2] = 1;
        if (m[1]) m_flag[3] = 1;
        for (int i = 2; i < 4; i++)
            if (m[i]) begin
                m_flag[i + 4] = 1;
                if (m_enb[i - 1]) m_flag[4] = 1;
            end
    endtask
    // Wait for the call, compare, acknowledge, then read back state
    task automatic serve();
        logic [7:0] e;
        int k;
        e = mvec();
        k = 0;
        while (irq !== 1'b1 && k < 40) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        if (k == 40) begin
            err_count++;
            give_verdict();
        end
        check("vector", vec, e);
        @(posedge clk_i) ack <= 1'b1;
        @(posedge clk_i) ack <= 1'b0;
        m_flag[m_idx] = 0;
        m_ctrl[0] = 0;
        #1 check("req", {7'h0, irq}, 8'h00);
        rdc("flags", 8'h08, m_flag[7:0]);
        rdc("ctrl", 8'h00, m_ctrl[7:0]);
    endtask
    // Main sequence
    initial begin
        {we, re, stk, ack, seg, addr, wd, tpin} = '0;
        {err_count, comparisons, m_ctrl, m_flag, m_enb, m_idx, m_edge} = '0;
        dir = 2'h3;
        rst_n_i = 1'b0;
        void'($urandom(32'he701));
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Reset values, then an unmapped read
        foreach (wd[i]) if (i < 6) rdc("reset", 8'(i * 4), 8'h00);
        rdc("unmapped", 8'h1C, 8'h00);
        // Pull selects, segment pin, filtered timer pins
        t = 8'($urandom);
        @(posedge clk_i) begin
            seg <= t[0];
            tpin <= t[2:1];
        end
        wr(8'h10, {6'h0, t[4:3]});
        repeat (12) @(posedge clk_i);
        #1 check("pull", {6'h0, pu}, {6'h0, t[4:3]});
        check("seg", {6'h0, oe, lseg}, 8'h00);
        check("tfilt", {6'h0, tf}, {6'h0, t[2:1]});
        rdc("levels", 8'h18, {3'h0, t[2:1], 3'h7});
        // Timers a and b on own vectors
        m_ctrl = 8'h19;
        for (int i = 0; i < 2; i++) begin
            m_ctrl[0] = 1;
            wr(8'h00, m_ctrl[7:0]);
            tovf(4'(1 << i));
            serve();
        end
        // Stack full holds off; flag kept with enable off
        @(posedge clk_i) stk <= 1'b1;
        m_ctrl = 8'h09;
        wr(8'h00, 8'h09);
        tovf(4'h1);
        repeat (6) @(posedge clk_i);
        #1 check("stackfull", {7'h0, irq}, 8'h00);
        wr(8'h00, 8'h01);
        rdc("kept", 8'h08, m_flag[7:0]);
        wr(8'h00, 8'h09);
        @(posedge clk_i) stk <= 1'b0;
        serve();
        // Every source pending at once: fixed priority order
        m_ctrl = 8'h3E;
        wr(8'h00, 8'h3E);
        m_edge = 5;
        wr(8'h0C, 8'h05);
        m_flag = 8'h1F;
        wr(8'h08, 8'h1F);
        for (int i = 0; i < 5; i++) begin
            m_ctrl[0] = 1;
            wr(8'h00, m_ctrl[7:0]);
            serve();
        end
        // Timers c, d and the periph pin through the multi path
        m_enb = 7;
        wr(8'h04, 8'h07);
        tovf(4'hC);
        far.pin(2, 0, 12);
        m_flag[5] = 1;
        m_ctrl = 8'h21;
        wr(8'h00, 8'h21);
        serve();
        far.pin(2, 1, 12);
        rdc("prise", 8'h08, m_flag[7:0]);
        m_flag = 0;
        wr(8'h08, 8'h00);
        // Edge modes on both lines; global off so flags only collect
        m_ctrl = 8'h06;
        wr(8'h00, 8'h06);
        for (int l = 0; l < 2; l++)
            for (int m = 0; m < 4; m++) begin
                wr(8'h0C, 8'(m << (2 * l)));
                for (int v = 0; v < 2; v++) begin
                    far.pin(l, v[0], 12);
                    if (m == 3 || m == 2 - v) m_flag[l] = 1;
                    rdc("edge", 8'h08, m_flag[7:0]);
                    m_flag = 0;
                    wr(8'h08, 8'h00);
                end
            end
        // Spike and output direction must not set a flag
        m_edge = 3;
        wr(8'h0C, 8'h03);
        far.pin(0, 0, 0);
        far.pin(0, 1, 12);
        rdc("spike", 8'h08, 8'h00);
        @(posedge clk_i) dir <= 2'h0;
        far.pin(0, 0, 12);
        far.pin(0, 1, 12);
        rdc("dir", 8'h08, 8'h00);
        // Line a with all enables calls its vector
        @(posedge clk_i) dir <= 2'h3;
        m_ctrl = 8'h07;
        wr(8'h00, 8'h07);
        far.pin(0, 0, 12);
        m_flag[0] = 1;
        serve();
        give_verdict();
    end
endmodule // testbench
